/* inc/rcbs_pkg.sv */
// Constants, types and states for the reset and clock bring-up sequencer
// Functional notes
// - Supply warning parks mirrors, then resets system
// - Power-up starts master PLL, then system reset
// - Every reset source restores defined default state; rate registers only on RESET or sense low
// - General-purpose pins tri-state during system reset
// - Master PLL runs except on RESET or sense low
// - Hardware releases only processor and master PLL resets
// - Processor clocks at full rate after reset
// - Mirror-link PLL powered down, dividers held reset
// - LVDS link I/O powered down and tri-stated
// - Other reset outputs stay asserted until firmware releases
// - Processor boots from external flash after reset
// - Firmware bring-up order enforced for link clocks
// - LVDS I/O held in reset until firmware
// - Hold internal resets 60 ms after sense rises
// - Sense low keeps reset, all pins tri-stated
package rcbs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SETTLE_MS = 60;
  // Cycles of lock wait after sense rises
  localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int unsigned CNT_W = 22;
  localparam int unsigned SYSRST_CYC = 16;
  localparam int unsigned PARK_TIMEOUT_CYC = 1024;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RATE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic BOOT_SRC_FLASH = 1'b1;
  localparam logic [2:0] CAUSE_POR = 3'h1;
  localparam logic [2:0] CAUSE_WARN = 3'h2;
  localparam logic [2:0] CAUSE_WDOG = 3'h4;
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned STAT_W = 7;

  // Firmware release controls, bit 0 is pll_enable
  typedef struct packed {
    logic [1:0] cpu_clk_div;
    logic int_release;
    logic ext_release;
    logic lvds_release;
    logic div_release;
    logic pll_enable;
  } rcbs_ctrl_t;

  typedef struct packed {
    logic [7:0] mirror_rate;
    logic [7:0] gen_rate;
  } rcbs_rate_t;

  localparam rcbs_ctrl_t CTRL_RST = rcbs_ctrl_t'(7'h00);
  localparam rcbs_rate_t RATE_RST = rcbs_rate_t'(16'h0000);

  typedef enum logic [2:0] {
    ST_POR, ST_PLL_WAIT, ST_SYS_RST, ST_RUN, ST_PARK, ST_HOLD
  } rcbs_state_t;
endpackage

/* hdl/rcbs_sequencer.sv */
// Reset and clock bring-up sequencer with firmware release registers
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
module rcbs_sequencer
  import rcbs_pkg::*;
#(
  parameter int unsigned PLL_SETTLE_CYCLES = SETTLE_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic POWER_ON_SENSE,
  input wire logic SUPPLY_OK_WARNING,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic PARK_DONE,
  input wire logic MIRROR_LINK_PLL_LOCK,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  output logic MASTER_PLL_RESET,
  output logic IO_HIZ,
  output logic GPIO_HIZ,
  output logic CPU_RESET,
  output logic INT_RESET,
  output logic PARK_REQ,
  output logic MIRROR_LINK_PLL_PWRDN,
  output logic MIRROR_DIV_RESET,
  output logic LVDS_PWRDN,
  output logic LVDS_HIZ,
  output logic EXT_RESET,
  output logic [1:0] CPU_CLK_DIV,
  output logic BOOT_FROM_FLASH,
  output logic [7:0] GEN_RATE,
  output logic [7:0] MIRROR_RATE
);

  // Sense low forces reset at once, without waiting for a clock
  logic arst;
  assign arst = RESET | ~POWER_ON_SENSE;

  // Input synchronisers; only the second stage is used
  logic sense_s1, sense_s2, warn_s1, warn_s2;
  always_ff @(posedge CORE_CLK or posedge arst)
  begin
    if (arst)
    begin
      sense_s1 <= 1'b0;
      sense_s2 <= 1'b0;
      warn_s1 <= 1'b0;
      warn_s2 <= 1'b0;
    end
    else
    begin
      sense_s1 <= 1'b1;
      sense_s2 <= sense_s1;
      warn_s1 <= SUPPLY_OK_WARNING;
      warn_s2 <= warn_s1;
    end
  end

  rcbs_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [2:0] cause, next_cause;
  logic in_reset;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + CNT_W'(1);
    next_cause = cause;
    case (state)
      ST_POR:
      begin
        next_cnt = '0;
        if (sense_s2)
          next_state = ST_PLL_WAIT;
      end
      ST_PLL_WAIT:
        if (cnt == CNT_W'(PLL_SETTLE_CYCLES - 1))
        begin
          next_state = ST_SYS_RST;
          next_cnt = '0;
        end
      ST_SYS_RST:
        if (cnt == CNT_W'(SYSRST_CYC - 1))
        begin
          next_cnt = '0;
          next_state = warn_s2 ? ST_RUN : ST_HOLD;
        end
      ST_RUN:
      begin
        next_cnt = '0;
        if (!warn_s2)
        begin
          next_state = ST_PARK;
          next_cause = CAUSE_WARN;
        end
        else if (WATCHDOG_TIMEOUT)
        begin
          next_state = ST_SYS_RST;
          next_cause = CAUSE_WDOG;
        end
      end
      ST_PARK:
        // Timeout stops a missing park answer from blocking reset
        if (PARK_DONE || cnt == CNT_W'(PARK_TIMEOUT_CYC - 1))
          next_state = ST_HOLD;
      ST_HOLD:
      begin
        next_cnt = '0;
        if (warn_s2)
          next_state = ST_SYS_RST;
      end
      default:
      begin
        next_state = ST_POR;
        next_cnt = '0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CORE_CLK or posedge arst)
  begin
    if (arst)
    begin
      state <= ST_POR;
      cnt <= '0;
      cause <= CAUSE_POR;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cause <= next_cause;
    end
  end

  // Reset and pin controls decoded from the sequencer state
  assign in_reset = (state != ST_RUN) && (state != ST_PARK);
  assign MASTER_PLL_RESET = (state == ST_POR);
  assign IO_HIZ = (state == ST_POR);
  assign GPIO_HIZ = in_reset;
  assign CPU_RESET = in_reset;
  assign PARK_REQ = (state == ST_PARK);
  assign BOOT_FROM_FLASH = BOOT_SRC_FLASH;

  // Firmware controlled releases; every system reset clears them
  rcbs_ctrl_t ctrl, next_ctrl, wctrl;
  rcbs_rate_t rate, next_rate, wrate;
  logic locked;
  assign wctrl = rcbs_ctrl_t'(REG_WDATA[CTRL_W-1:0]);
  assign wrate = rcbs_rate_t'(REG_WDATA[RATE_W-1:0]);
  assign locked = ctrl.pll_enable & MIRROR_LINK_PLL_LOCK;

  always_comb
  begin
    next_ctrl = ctrl;
    next_rate = rate;
    if (in_reset)
      next_ctrl = CTRL_RST;
    else if (REG_WR && REG_ADDR == ADDR_CTRL)
    begin
      next_ctrl = wctrl;
      // Dividers start only on a locked PLL, external resets no earlier than them
      next_ctrl.div_release = wctrl.div_release & wctrl.pll_enable & locked;
      next_ctrl.ext_release = wctrl.ext_release & next_ctrl.div_release;
    end
    else if (REG_WR && REG_ADDR == ADDR_RATE)
    begin
      // Generator rate only while its PLL is off
      if (!ctrl.pll_enable)
        next_rate.gen_rate = wrate.gen_rate;
      // Mirror clock rate only after lock, before dividers run
      if (locked && !ctrl.div_release)
        next_rate.mirror_rate = wrate.mirror_rate;
    end
  end

  always_ff @(posedge CORE_CLK or posedge arst)
  begin
    if (arst)
    begin
      ctrl <= CTRL_RST;
      rate <= RATE_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      rate <= next_rate;
    end
  end

  assign INT_RESET = in_reset | ~ctrl.int_release;
  assign MIRROR_LINK_PLL_PWRDN = ~ctrl.pll_enable;
  assign MIRROR_DIV_RESET = ~ctrl.div_release;
  assign LVDS_PWRDN = ~ctrl.lvds_release;
  assign LVDS_HIZ = ~ctrl.lvds_release;
  assign EXT_RESET = ~ctrl.ext_release;
  assign CPU_CLK_DIV = ctrl.cpu_clk_div;
  assign GEN_RATE = rate.gen_rate;
  assign MIRROR_RATE = rate.mirror_rate;

  // Read port, data one cycle after the strobe, zero when unmapped
  logic [DATA_W-1:0] next_rdata;
  logic [STAT_W-1:0] status;
  assign status = {MIRROR_LINK_PLL_LOCK, state, cause};

  always_comb
  begin
    next_rdata = '0;
    if (REG_RD)
      case (REG_ADDR)
        ADDR_CTRL: next_rdata = DATA_W'(ctrl);
        ADDR_RATE: next_rdata = DATA_W'(rate);
        ADDR_STATUS: next_rdata = DATA_W'(status);
        default: next_rdata = '0;
      endcase
  end

  always_ff @(posedge CORE_CLK or posedge arst)
  begin
    if (arst)
      REG_RDATA <= '0;
    else
      REG_RDATA <= next_rdata;
  end

  // Checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (arst);

  sequence s_warn_in_run;
    state == ST_RUN && !warn_s2;
  endsequence

  sequence s_parking;
    PARK_REQ && !CPU_RESET;
  endsequence

  // Own count of lock wait cycles, kept apart from the sequencer counter
  logic [CNT_W-1:0] wait_len, next_wait_len;

  always_comb
  begin
    next_wait_len = '0;
    if (state == ST_PLL_WAIT)
      next_wait_len = wait_len + CNT_W'(1);
  end

  always_ff @(posedge CORE_CLK or posedge arst)
  begin
    if (arst)
      wait_len <= '0;
    else
      wait_len <= next_wait_len;
  end

  a_settle_count: assert property (
    $fell(state == ST_PLL_WAIT) |-> wait_len == CNT_W'(PLL_SETTLE_CYCLES) && state == ST_SYS_RST)
    else $error("lock wait length wrong");

  a_park_first: assert property (
    s_warn_in_run |=> s_parking)
    else $error("warning did not start a park");

  a_park_then_rst: assert property (
    $fell(PARK_REQ) |-> state == ST_HOLD && CPU_RESET)
    else $error("park did not end in reset");

  a_wdog_keeps_pll: assert property (
    state == ST_RUN && warn_s2 && WATCHDOG_TIMEOUT |=> CPU_RESET && !MASTER_PLL_RESET)
    else $error("watchdog reset wrong");

  a_sysrst_hold: assert property (
    $rose(state == ST_SYS_RST) |-> CPU_RESET [*8])
    else $error("system reset too short");

  a_gpio_hiz: assert property (
    CPU_RESET |-> GPIO_HIZ)
    else $error("pins driven during reset");

  a_gpio_release: assert property (
    $fell(GPIO_HIZ) |-> $past(state == ST_SYS_RST) && !CPU_RESET)
    else $error("pins driven before reset ended");

  a_fw_defaults: assert property (
    state == ST_SYS_RST |=> MIRROR_LINK_PLL_PWRDN && MIRROR_DIV_RESET && LVDS_HIZ
      && EXT_RESET && INT_RESET)
    else $error("firmware resets not restored");

  a_div_order: assert property (
    $fell(MIRROR_DIV_RESET) |-> !MIRROR_LINK_PLL_PWRDN && $past(MIRROR_LINK_PLL_LOCK))
    else $error("dividers released before lock");

  a_ext_order: assert property (
    $fell(EXT_RESET) |-> !MIRROR_DIV_RESET)
    else $error("external reset released early");

  a_full_rate: assert property (
    $fell(CPU_RESET) |-> CPU_CLK_DIV == 2'h0)
    else $error("boot not at full rate");

  a_status_read: assert property (
    REG_RD && REG_ADDR == ADDR_STATUS |=> REG_RDATA[2:0] == $past(cause))
    else $error("status read wrong");

endmodule

/* verification/rcbs_power_monitor.sv */
// Power monitor model driving sense and supply warning
`timescale 1ns/100ps
module rcbs_power_monitor #(
  parameter int unsigned SETTLE_HOLD = 8
)
(
  input wire logic clk,
  input wire logic supply_on,
  input wire logic supply_sag,
  output logic power_on_sense,
  output logic supply_ok_warning
);
  int unsigned cnt;
  // Settling count; sense follows a supply rise after SETTLE_HOLD cycles, a supply drop at once
  always_ff @(posedge clk)
  begin
    if (!supply_on)
      cnt <= 0;
    else if (cnt < SETTLE_HOLD)
      cnt <= cnt + 1;
  end
  assign power_on_sense = supply_on && (cnt >= SETTLE_HOLD);
  assign supply_ok_warning = supply_on && !supply_sag;
endmodule

/* verification/rcbs_sequencer_bench.sv */
// Self-checking bench for the reset and clock bring-up sequencer
`timescale 1ns/100ps
module rcbs_sequencer_bench;
  import rcbs_pkg::*;
  logic CORE_CLK, RESET, POWER_ON_SENSE, SUPPLY_OK_WARNING, WATCHDOG_TIMEOUT, PARK_DONE;
  logic MIRROR_LINK_PLL_LOCK, REG_WR, REG_RD, supply_on, supply_sag;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA, REG_RDATA, d;
  logic MASTER_PLL_RESET, IO_HIZ, GPIO_HIZ, CPU_RESET, INT_RESET, PARK_REQ, MIRROR_LINK_PLL_PWRDN;
  logic MIRROR_DIV_RESET, LVDS_PWRDN, LVDS_HIZ, EXT_RESET, BOOT_FROM_FLASH;
  logic [1:0] CPU_CLK_DIV;
  logic [7:0] GEN_RATE, MIRROR_RATE;
  int fails = 0;
  int checked = 0;
  int n;
  // Short lock wait keeps the run brief
  rcbs_sequencer #(.PLL_SETTLE_CYCLES(20)) dut (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .POWER_ON_SENSE(POWER_ON_SENSE), .SUPPLY_OK_WARNING(SUPPLY_OK_WARNING),
    .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .PARK_DONE(PARK_DONE),
    .MIRROR_LINK_PLL_LOCK(MIRROR_LINK_PLL_LOCK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .MASTER_PLL_RESET(MASTER_PLL_RESET), .IO_HIZ(IO_HIZ), .GPIO_HIZ(GPIO_HIZ),
    .CPU_RESET(CPU_RESET), .INT_RESET(INT_RESET), .PARK_REQ(PARK_REQ),
    .MIRROR_LINK_PLL_PWRDN(MIRROR_LINK_PLL_PWRDN), .MIRROR_DIV_RESET(MIRROR_DIV_RESET),
    .LVDS_PWRDN(LVDS_PWRDN), .LVDS_HIZ(LVDS_HIZ), .EXT_RESET(EXT_RESET),
    .CPU_CLK_DIV(CPU_CLK_DIV), .BOOT_FROM_FLASH(BOOT_FROM_FLASH), .GEN_RATE(GEN_RATE),
    .MIRROR_RATE(MIRROR_RATE));
  rcbs_power_monitor mon (.clk(CORE_CLK), .supply_on(supply_on), .supply_sag(supply_sag),
    .power_on_sense(POWER_ON_SENSE), .supply_ok_warning(SUPPLY_OK_WARNING));
  // 50 MHz reference
  initial
  begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  task automatic results();
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Reset-related outputs gathered in one word
  function automatic logic [10:0] outs();
    return {IO_HIZ, MASTER_PLL_RESET, CPU_RESET, GPIO_HIZ, INT_RESET, MIRROR_LINK_PLL_PWRDN,
      MIRROR_DIV_RESET, LVDS_PWRDN, LVDS_HIZ, EXT_RESET, PARK_REQ};
  endfunction
  function automatic logic pick(input int k);
    return (k == 0) ? CPU_RESET : (k == 1) ? PARK_REQ : POWER_ON_SENSE;
  endfunction
  // Bounded wait; running out ends the run
  task automatic wt(input int k, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (pick(k) !== lvl)
    begin
      if (cnt == lim)
      begin
        fails++;
        results();
      end
      @(posedge CORE_CLK);
      #1;
      cnt++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask
  task automatic s_defaults();
    wr(ADDR_CTRL, 32'h0000_0001);
    chk("por_outs", outs(), 11'h7fe);
    chk("clk_div", CPU_CLK_DIV, 2'h0);
    chk("boot_src", BOOT_FROM_FLASH, 1'b1);
  endtask
  task automatic s_powerup();
    supply_on <= 1'b1;
    wt(2, 1'b1, 50, n);
    repeat (4) @(posedge CORE_CLK);
    #1 chk("pll_first", outs(), 11'h1fe);
    wt(0, 1'b0, 60, n);
    chk("boot_wait", (n + 4 >= 36) && (n + 4 <= 41), 1'b1);
    chk("run_outs", outs(), 11'h07e);
  endtask
  task automatic s_bringup();
    rd(ADDR_STATUS, d);
    chk("status", d, 32'h19);
    wr(ADDR_CTRL, 32'h0000_0008);
    rd(ADDR_CTRL, d);
    chk("ext_early", d, 32'h0);
    wr(ADDR_RATE, 32'h0000_00a5);
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0003);
    rd(ADDR_CTRL, d);
    chk("div_nolock", d, 32'h1);
    MIRROR_LINK_PLL_LOCK <= 1'b1;
    wr(ADDR_RATE, 32'h0000_3c5a);
    chk("rates", {GEN_RATE, MIRROR_RATE}, 16'ha53c);
    rd(ADDR_RATE, d);
    chk("rate_rd", d, 32'h3ca5);
    wr(ADDR_CTRL, 32'h0000_0003);
    chk("div_run", {MIRROR_LINK_PLL_PWRDN, MIRROR_DIV_RESET, EXT_RESET}, 3'h1);
    wr(ADDR_CTRL, 32'h0000_007f);
    chk("clk_div_fw", CPU_CLK_DIV, 2'h3);
    rd(4'hc, d);
    chk("unmapped", d, 32'h0);
    chk("released", outs(), 11'h000);
  endtask
  task automatic s_watchdog();
    WATCHDOG_TIMEOUT <= 1'b1;
    @(posedge CORE_CLK);
    WATCHDOG_TIMEOUT <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    #1 chk("wd_outs", outs(), 11'h1fe);
    chk("wd_div", CPU_CLK_DIV, 2'h0);
    wt(0, 1'b0, 40, n);
    rd(ADDR_STATUS, d);
    chk("wd_cause", d, 32'h5c);
  endtask
  task automatic s_park(input logic done);
    supply_sag <= 1'b1;
    wt(1, 1'b1, 10, n);
    chk("park_first", outs(), 11'h07f);
    PARK_DONE <= done;
    wt(1, 1'b0, 1100, n);
    PARK_DONE <= 1'b0;
    if (!done)
      chk("park_limit", (n >= 1020) && (n <= 1030), 1'b1);
    @(posedge CORE_CLK);
    #1 chk("hold_outs", outs(), 11'h1fe);
    rd(ADDR_STATUS, d);
    chk("hold_stat", d, 32'h6a);
    supply_sag <= 1'b0;
    wt(0, 1'b0, 40, n);
  endtask
  // Main sequence
  initial
  begin
    {WATCHDOG_TIMEOUT, PARK_DONE, MIRROR_LINK_PLL_LOCK, REG_WR, REG_RD} = '0;
    {supply_on, supply_sag, REG_ADDR, REG_WDATA} = '0;
    RESET = 1'b1;
    repeat (20) @(posedge CORE_CLK);
    RESET <= 1'b0;
    #1 s_defaults();
    s_powerup();
    s_bringup();
    s_watchdog();
    s_park(1'b1);
    s_park(1'b0);
    supply_on <= 1'b0;
    #1 chk("sense_drop", outs(), 11'h7fe);
    results();
  end
endmodule
